// ---- bench/cpu_data_register_file_test.sv ----
`timescale 1ns/1ps
module cpu_data_register_file_test
	import regfile_pkg::*;
;
	logic        sys_clk = 0;
	logic        rstn = 0;
	bank_wr_s    fix_wr = '0;
	bank_wr_s    flt_wr = '0;
	logic [4:0]  fix_rd_idx = '0;
	logic [4:0]  flt_rd_idx = '0;
	logic [63:0] fix_rd_data, flt_rd_data;
	logic        pc_advance = 0;
	logic [5:0]  packet_bytes = '0;
	flow_s       flow = '0;
	logic [31:0] packet_pointer, saved_link_address_reg;
	logic [31:0] irq_state_word, decode_state_word, execute_state_word;
	logic        stack_fault;
	status_wr_s  status_wr = '0;
	int          errors = 0;
	int          samples_checked = 0;
	// Fixed bank at 0-15, float bank at 16-47
	word_t       r [48] = '{default: '0};
	word_t       lk [$];
	word_t       pc = '0;
	word_t       link = '0;
	word_t       d, e, q;
	bank_wr_s    a, b;

	cpu_data_register_file i_dut (.sys_clk, .rstn, .fix_wr, .flt_wr, .fix_rd_idx, .flt_rd_idx,
		.fix_rd_data, .flt_rd_data, .pc_advance, .packet_bytes, .flow, .packet_pointer,
		.saved_link_address_reg, .stack_fault, .status_wr, .irq_state_word,
		.decode_state_word, .execute_state_word);

	always #2 sys_clk = ~sys_clk;

	task automatic cmp(string n, logic [63:0] x, logic [63:0] g);
		samples_checked++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask

	function automatic pair_t pair(int base, int i);
		return {r[base + (i | 1)], r[base + (i & 30)]};
	endfunction

	function automatic bank_wr_s rnd(int n);
		return '{1'($urandom), 1'($urandom), 5'($urandom % n), {$urandom, $urandom}};
	endfunction

	task automatic upd(int base, bank_wr_s s);
		int i;
		i = base + s.idx;
		if (s.en && s.wide) begin
			r[i & ~1] = s.data[31:0];
			r[i | 1] = s.data[63:32];
		end else if (s.en)
			r[i] = s.data[31:0];
	endtask

	task automatic read_all();
		for (int i = 0; i < 32; i++) begin
			@(posedge sys_clk);
			fix_rd_idx <= 5'(i % 16);
			flt_rd_idx <= 5'(i);
			@(negedge sys_clk);
			cmp("fix pair", pair(0, i % 16), fix_rd_data);
			cmp("float pair", pair(16, i), flt_rd_data);
		end
	endtask

	// Advance held high with call or return, so it must be ignored
	task automatic flw(flow_e op, word_t t, word_t l);
		@(posedge sys_clk);
		flow <= '{op, t, l};
		pc_advance <= 1;
		@(posedge sys_clk);
		flow <= '0;
		pc_advance <= 0;
		if (op == FLOW_CALL) begin
			// Model a full stack: the call still lands but pushes nothing
			if (lk.size() < 8)
				lk.push_back(link);
			link = l;
			pc = t;
		end else begin
			pc = link;
			if (lk.size() > 0)
				link = lk.pop_back();
		end
		@(negedge sys_clk);
		cmp("pointer", pc, packet_pointer);
		cmp("link", link, saved_link_address_reg);
	endtask

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		void'($urandom(41950));
		repeat (4) @(posedge sys_clk);
		rstn <= 1;
		read_all();
		$display("test reset done");
		repeat (300) begin
			@(posedge sys_clk);
			a = rnd(16);
			b = rnd(32);
			fix_wr <= a;
			flt_wr <= b;
			upd(0, a);
			upd(16, b);
		end
		@(posedge sys_clk);
		fix_wr <= '0;
		flt_wr <= '0;
		read_all();
		$display("test banks done");
		repeat (50) begin
			@(posedge sys_clk);
			q = $urandom % 64;
			pc_advance <= 1;
			packet_bytes <= 6'(q);
			pc += q;
		end
		@(posedge sys_clk);
		pc_advance <= 0;
		@(negedge sys_clk);
		cmp("pointer", pc, packet_pointer);
		for (int i = 0; i < 8; i++)
			flw(FLOW_CALL, $urandom, $urandom);
		cmp("fault", 64'h0, stack_fault);
		repeat (8) flw(FLOW_RET, '0, '0);
		cmp("fault", 64'h0, stack_fault);
		flw(FLOW_RET, '0, '0);
		cmp("fault", 64'h1, stack_fault);
		// Call and return on adjacent edges: the old link comes straight back
		e = $urandom;
		@(posedge sys_clk);
		flow <= '{FLOW_CALL, $urandom, e};
		@(posedge sys_clk);
		flow <= '{FLOW_RET, '0, '0};
		@(posedge sys_clk);
		flow <= '0;
		pc = e;
		@(negedge sys_clk);
		cmp("pointer", pc, packet_pointer);
		cmp("link", link, saved_link_address_reg);
		$display("test flow done");
		// Second reset in mid-run, with live data in both banks and a set fault
		@(posedge sys_clk);
		rstn <= 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1;
		r = '{default: '0};
		lk.delete();
		pc = '0;
		link = '0;
		read_all();
		cmp("pointer", pc, packet_pointer);
		cmp("link", link, saved_link_address_reg);
		cmp("fault", 64'h0, stack_fault);
		$display("test mid reset done");
		for (int i = 0; i < 8; i++)
			flw(FLOW_CALL, $urandom, $urandom);
		cmp("fault", 64'h0, stack_fault);
		flw(FLOW_CALL, $urandom, $urandom);
		cmp("fault", 64'h1, stack_fault);
		repeat (8) flw(FLOW_RET, '0, '0);
		$display("test overflow done");
		d = $urandom;
		e = $urandom;
		q = $urandom;
		@(posedge sys_clk);
		status_wr <= '{1'h1, 1'h1, d, e, 1'h1, q};
		@(posedge sys_clk);
		status_wr <= '0;
		@(negedge sys_clk);
		cmp("decode", d, decode_state_word);
		cmp("execute", e, execute_state_word);
		cmp("irq", q, irq_state_word);
		$display("test status done");
		final_report();
	end

	initial begin
		#200000;
		errors++;
		final_report();
	end
endmodule

// ---- design/cpu_data_register_file.sv ----
`timescale 1ns/1ps
`include "regfile_consts.svh"
module cpu_data_register_file
	import regfile_pkg::*;
#(
	parameter int FIX_N = `FIX_COUNT,
	parameter int FLT_N = `FLT_COUNT,
	parameter int DEPTH = `STACK_DEPTH
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire bank_wr_s    fix_wr,
	input  wire bank_wr_s    flt_wr,
	input  wire logic [4:0]  fix_rd_idx,
	input  wire logic [4:0]  flt_rd_idx,
	output logic [63:0]      fix_rd_data,
	output logic [63:0]      flt_rd_data,
	input  wire logic        pc_advance,
	input  wire logic [5:0]  packet_bytes,
	input  wire flow_s       flow,
	output logic [31:0]      packet_pointer,
	output logic [31:0]      saved_link_address_reg,
	output logic             stack_fault,
	input  wire status_wr_s  status_wr,
	output logic [31:0]      irq_state_word,
	output logic [31:0]      decode_state_word,
	output logic [31:0]      execute_state_word
);
	localparam int SPW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [FIX_N-1:0][31:0] fix;
		logic [FLT_N-1:0][31:0] flt;
		logic [31:0]            pc;
		logic [31:0]            link;
		logic [DEPTH-1:0][31:0] stack;
		logic [SPW-1:0]         sp;
		logic                   fault;
		logic [31:0]            irq;
		logic [31:0]            dec;
		logic [31:0]            exe;
	} state_s;

	state_s st;
	state_s next_st;

	// Pair read: even index gives low word, next odd gives high word
	function automatic logic [4:0] even_of(input logic [4:0] idx);
		return {idx[4:1], 1'b0};
	endfunction

	assign fix_rd_data = {st.fix[4'(even_of(fix_rd_idx)) + 4'd1],
		st.fix[4'(even_of(fix_rd_idx))]};
	assign flt_rd_data = {st.flt[even_of(flt_rd_idx) + 5'd1],
		st.flt[even_of(flt_rd_idx)]};
	assign packet_pointer         = st.pc;
	assign saved_link_address_reg = st.link;
	assign stack_fault            = st.fault;
	assign irq_state_word         = st.irq;
	assign decode_state_word      = st.dec;
	assign execute_state_word     = st.exe;

	always_comb begin
		next_st = st;
		if (fix_wr.en) begin
			if (fix_wr.wide) begin
				next_st.fix[4'(even_of(fix_wr.idx))]        = fix_wr.data[31:0];
				next_st.fix[4'(even_of(fix_wr.idx)) + 4'd1] = fix_wr.data[63:32];
			end else begin
				next_st.fix[4'(fix_wr.idx)] = fix_wr.data[31:0];
			end
		end
		if (flt_wr.en) begin
			if (flt_wr.wide) begin
				next_st.flt[even_of(flt_wr.idx)]        = flt_wr.data[31:0];
				next_st.flt[even_of(flt_wr.idx) + 5'd1] = flt_wr.data[63:32];
			end else begin
				next_st.flt[flt_wr.idx] = flt_wr.data[31:0];
			end
		end
		// Flow change wins over sequential advance
		unique case (flow.op)
			FLOW_CALL: begin
				if (st.sp == SPW'(DEPTH)) begin
					next_st.fault = 1'b1;
				end else begin
					next_st.stack[st.sp[$clog2(DEPTH)-1:0]] = st.link;
					next_st.sp = st.sp + SPW'(1);
				end
				next_st.link = flow.link;
				next_st.pc   = flow.target;
			end
			FLOW_RET: begin
				next_st.pc = st.link;
				if (st.sp == '0) begin
					// Underflow leaves link unchanged; flagged for software
					next_st.fault = 1'b1;
				end else begin
					next_st.link = st.stack[st.sp[$clog2(DEPTH)-1:0] - 1'b1];
					next_st.sp   = st.sp - SPW'(1);
				end
			end
			default: begin
				if (pc_advance) begin
					next_st.pc = st.pc + 32'(packet_bytes);
				end
			end
		endcase
		if (status_wr.irq_load) begin
			next_st.irq = status_wr.irq_data;
		end
		if (status_wr.dec_load) begin
			next_st.dec = status_wr.dec_data;
		end
		if (status_wr.exe_load) begin
			next_st.exe = status_wr.exe_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			st       <= '0;
			st.pc    <= `PC_RESET;
			st.irq   <= `STATUS_ZERO;
			st.dec   <= `STATUS_ZERO;
			st.exe   <= `STATUS_ZERO;
		end else begin
			st <= next_st;
		end
	end

	// Reset is synchronous: the banks read zero one edge after it is seen
	a_reset_clears: assert property (@(posedge sys_clk)
		!rstn |=> st.fix == '0 && st.flt == '0)
		else $error("banks not cleared by reset");
	a_reset_flow: assert property (@(posedge sys_clk)
		!rstn |=> packet_pointer == `PC_RESET && saved_link_address_reg == '0 && !stack_fault)
		else $error("flow state not cleared by reset");
	a_fix_single: assert property (@(posedge sys_clk) disable iff (!rstn)
		fix_wr.en && !fix_wr.wide
		|=> st.fix[4'($past(fix_wr.idx))] == $past(fix_wr.data[31:0]))
		else $error("fixed single write lost");
	a_flt_single: assert property (@(posedge sys_clk) disable iff (!rstn)
		flt_wr.en && !flt_wr.wide
		|=> st.flt[$past(flt_wr.idx)] == $past(flt_wr.data[31:0]))
		else $error("float single write lost");
	// Read port compared on any index that falls in the written pair
	a_fix_pair_hi: assert property (@(posedge sys_clk) disable iff (!rstn)
		fix_wr.en && fix_wr.wide
		|=> fix_rd_idx[3:1] != $past(fix_wr.idx[3:1]) || fix_rd_data == $past(fix_wr.data))
		else $error("fixed pair readback wrong");
	a_flt_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
		flt_wr.en && flt_wr.wide
		|=> flt_rd_idx[4:1] != $past(flt_wr.idx[4:1]) || flt_rd_data == $past(flt_wr.data))
		else $error("float pair readback wrong");
	// Checked on the storage itself, apart from the read mux
	a_pair_order: assert property (@(posedge sys_clk) disable iff (!rstn)
		flt_wr.en && flt_wr.wide
		|=> st.flt[{$past(flt_wr.idx[4:1]), 1'b0}] == $past(flt_wr.data[31:0]) &&
		st.flt[{$past(flt_wr.idx[4:1]), 1'b1}] == $past(flt_wr.data[63:32]))
		else $error("pair words in wrong registers");
	a_pc_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_NONE && pc_advance
		|=> packet_pointer == $past(packet_pointer) + 32'($past(packet_bytes)))
		else $error("pointer did not advance");
	a_pc_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_NONE && !pc_advance |=> $stable(packet_pointer))
		else $error("pointer moved while idle");
	// Advance is held off on flow edges, so the pointer must equal the target
	a_call_target: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_CALL |=> packet_pointer == $past(flow.target))
		else $error("call did not take its target");
	a_call_link: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_CALL |=> saved_link_address_reg == $past(flow.link))
		else $error("call did not load link");
	a_ret_target: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_RET |=> packet_pointer == $past(saved_link_address_reg))
		else $error("return target wrong");
	// A call that finds room on the stack and its return on adjacent edges hand back the old link
	a_call_ret_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_CALL && st.sp != SPW'(DEPTH) ##1 flow.op == FLOW_RET
		|=> saved_link_address_reg == $past(saved_link_address_reg, 2))
		else $error("link not restored");
	a_stack_full: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_CALL && st.sp == SPW'(DEPTH) |=> stack_fault && st.sp == SPW'(DEPTH))
		else $error("overflow not flagged");
	a_stack_empty: assert property (@(posedge sys_clk) disable iff (!rstn)
		flow.op == FLOW_RET && st.sp == '0 |=> stack_fault && $stable(saved_link_address_reg))
		else $error("underflow not flagged");
	// Only reset clears it, so a late look by software still sees the fault
	a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
		stack_fault |=> stack_fault)
		else $error("stack fault dropped");
	a_status_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_wr.dec_load |=> decode_state_word == $past(status_wr.dec_data))
		else $error("decode word not loaded");
	a_exe_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_wr.exe_load |=> execute_state_word == $past(status_wr.exe_data))
		else $error("execute word not loaded");
	a_irq_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		status_wr.irq_load |=> irq_state_word == $past(status_wr.irq_data))
		else $error("interrupt word not loaded");
	// Saved decode and execute status must survive untouched until software reloads it
	a_status_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
		!status_wr.dec_load && !status_wr.exe_load
		|=> $stable(decode_state_word) && $stable(execute_state_word))
		else $error("status word changed without a load");
endmodule

// ---- design/regfile_consts.svh ----
`ifndef REGFILE_CONSTS_SVH
`define REGFILE_CONSTS_SVH
`define FIX_COUNT      16
`define FLT_COUNT      32
`define WORD_BITS      32
`define WORD_ZERO      32'h0000_0000
`define PC_RESET       32'h0000_0000
`define STACK_DEPTH    8
`define STATUS_ZERO    32'h0000_0000
`endif

// ---- design/regfile_pkg.sv ----
`include "regfile_consts.svh"
package regfile_pkg;
	typedef logic [`WORD_BITS-1:0]   word_t;
	typedef logic [2*`WORD_BITS-1:0] pair_t;
	typedef enum logic [1:0] {
		FLOW_NONE,
		FLOW_CALL,
		FLOW_RET
	} flow_e;
	// One write port per bank; wide selects a pair at an even index
	typedef struct packed {
		logic        en;
		logic        wide;
		logic [4:0]  idx;
		pair_t       data;
	} bank_wr_s;
	typedef struct packed {
		flow_e       op;
		word_t       target;
		word_t       link;
	} flow_s;
	typedef struct packed {
		logic        dec_load;
		logic        exe_load;
		word_t       dec_data;
		word_t       exe_data;
		logic        irq_load;
		word_t       irq_data;
	} status_wr_s;
endpackage
